// ===== core/lcc_pkg.sv
// Contract
// - cap priority requests per fairness interval
// - link control set view E0h, clear E4h
// - source bit one: roll on external tick
// - source bit zero: roll after 3072 offset ticks
// - master and root: cycle start each rollover
// - master off: load received cycle starts
// - overlong clears master; set refused while pending
// - count enable zero holds the offset between loads and external tick rolls
// - queue phy packets when enabled and running
// - accept self-id packets only when enabled
// - node id is bus over node index
// - bus reset clears valid; new number sets
// - root flag set when phy reports root
// - cable power flag follows phy status
// - writable ten-bit bus index, resets ones
// - node index loaded after self-id phase
// - write one sets or clears; zeros nothing
// - both views read the same contents
// - offset mod 3072, count 8000, seconds 128; with source bit one the offset runs on past 3071 and holds at 4095
package lcc_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_FAIRNESS = 8'hdc;
    localparam logic [7:0] OFS_LINK_SET = 8'he0;
    localparam logic [7:0] OFS_LINK_CLR = 8'he4;
    localparam logic [7:0] OFS_NODE_ID = 8'he8;

    // link control field positions
    localparam int LC_ROLL_SRC_BIT = 22;
    localparam int LC_MASTER_BIT = 21;
    localparam int LC_CNT_EN_BIT = 20;
    localparam int LC_PHY_PKT_BIT = 10;
    localparam int LC_SELF_ID_BIT = 9;

    // node identity field layout
    localparam int NI_VALID_BIT = 31;
    localparam int NI_ROOT_BIT = 30;
    localparam int NI_POWER_BIT = 27;
    localparam int NI_BUS_LSB = 6;
    localparam int BUS_W = 10;
    localparam int NODE_W = 6;

    // reset values
    localparam logic [7:0] FAIRNESS_RESET = 8'h00;
    localparam logic [BUS_W-1:0] BUS_INDEX_RESET = 10'h3ff;
    localparam logic [NODE_W-1:0] NODE_INDEX_RESET = 6'h3f;

    // timing: offset clock derived from the system clock by phase accumulation
    localparam int CLK_KHZ = 200000;
    localparam int OFFSET_CLK_KHZ = 24576;
    localparam int CYCLE_PERIOD_US = 125;
    localparam int OFFSET_MOD = OFFSET_CLK_KHZ * CYCLE_PERIOD_US / 1000;
    localparam int COUNT_MOD = 8000;
    localparam int SECONDS_MOD = 128;
    localparam int OFS_W = 12;
    localparam int CNT_W = 13;
    localparam int SEC_W = 7;
    localparam int PHASE_W = 18;

endpackage

// ===== core/lcc_cycle_timer.sv
module lcc_cycle_timer
    import lcc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic count_en,
    input wire logic ext_source,
    input wire logic ext_tick,
    input wire logic load,
    input wire logic [31:0] load_value,
    output logic [OFS_W-1:0] offset,
    output logic [CNT_W-1:0] count,
    output logic [SEC_W-1:0] seconds,
    output logic rollover
);

    logic [PHASE_W-1:0] phase;
    wire [PHASE_W:0] phase_sum = {1'b0, phase} + (PHASE_W+1)'(OFFSET_CLK_KHZ);
    wire tick = phase_sum >= (PHASE_W+1)'(CLK_KHZ);
    wire [PHASE_W-1:0] next_phase = tick ? PHASE_W'(phase_sum - (PHASE_W+1)'(CLK_KHZ))
                                         : phase_sum[PHASE_W-1:0];
    wire offset_last = offset == OFS_W'(OFFSET_MOD - 1);
    // external mode holds at full scale rather than wrapping if the tick is late
    wire inc_ok = ext_source ? (offset != {OFS_W{1'b1}}) : 1'b1;
    wire int_roll = !ext_source && count_en && tick && offset_last;
    wire ext_roll = ext_source && ext_tick;
    wire roll = int_roll || ext_roll;
    wire count_last = count == CNT_W'(COUNT_MOD - 1);
    wire [OFS_W-1:0] next_offset = load ? load_value[OFS_W-1:0]
                                 : roll ? '0
                                 : (count_en && tick && inc_ok) ? offset + 1'b1
                                 : offset;
    wire [CNT_W-1:0] next_count = load ? load_value[24:12]
                                : roll ? (count_last ? '0 : count + 1'b1)
                                : count;
    wire [SEC_W-1:0] next_seconds = load ? load_value[31:25]
                                  : (roll && count_last) ? seconds + 1'b1
                                  : seconds;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            phase <= '0;
            offset <= '0;
            count <= '0;
            seconds <= '0;
            rollover <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            offset <= next_offset;
            count <= next_count;
            seconds <= next_seconds;
            rollover <= roll && !load;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_int_roll;
        int_roll && !load |=> offset == '0 && rollover;
    endproperty
    a_int_roll: assert property (p_int_roll) else $error("internal rollover missed");

    property p_ext_roll;
        ext_source && ext_tick && !load |=> offset == '0 && rollover;
    endproperty
    a_ext_roll: assert property (p_ext_roll) else $error("external rollover missed");

    property p_hold;
        !count_en && !load && !ext_roll |=> offset == $past(offset);
    endproperty
    a_hold: assert property (p_hold) else $error("offset moved while disabled");

    property p_count_wrap;
        roll && !load && count_last |=> count == '0 && seconds == $past(seconds) + 1'b1;
    endproperty
    a_count_wrap: assert property (p_count_wrap) else $error("count wrap wrong");

endmodule

// ===== core/lcc_link_core_control_regs.sv
module lcc_link_core_control_regs
    import lcc_pkg::*;
#(
    parameter logic [7:0] PRI_REQ_LIMIT = FAIRNESS_RESET
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rd_valid,
    input wire logic external_cycle_tick_input,
    input wire logic overlong_cycle_event,
    input wire logic interrupt_event_register_overlong,
    input wire logic phy_bus_reset,
    input wire logic phy_node_update,
    input wire logic [NODE_W-1:0] phy_node_number,
    input wire logic phy_is_root,
    input wire logic phy_cable_power,
    input wire logic rx_cycle_start,
    input wire logic [31:0] rx_cycle_start_data,
    input wire logic rx_phy_packet,
    input wire logic rx_self_id_packet,
    input wire logic async_receive_request_run,
    input wire logic pri_arb_want,
    input wire logic fairness_interval_start,
    output logic pri_arb_req,
    output logic cycle_start_send,
    output logic queue_phy_packet,
    output logic queue_self_id_packet,
    output logic rollover_source_select,
    output logic cycle_start_generator_enable,
    output logic offset_count_enable,
    output logic accept_phy_packets,
    output logic accept_self_identification,
    output logic node_number_valid,
    output logic node_root,
    output logic cable_power_ok,
    output logic [BUS_W-1:0] bus_index,
    output logic [NODE_W-1:0] physical_node_index,
    output logic [BUS_W+NODE_W-1:0] node_id,
    output logic [OFS_W-1:0] cycle_tick_offset,
    output logic [CNT_W-1:0] cycle_counter_field,
    output logic [SEC_W-1:0] cycle_seconds_field
);

    function automatic logic sc_next(input logic cur, input logic set_b, input logic clr_b);
        sc_next = set_b ? 1'b1 : (clr_b ? 1'b0 : cur);
    endfunction

    function automatic logic [31:0] place(input logic v, input int pos);
        place = v ? (32'h1 << pos) : 32'h0;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // register decode

    wire sel_fair = reg_addr == OFS_FAIRNESS;
    wire sel_set = reg_addr == OFS_LINK_SET;
    wire sel_clr = reg_addr == OFS_LINK_CLR;
    wire sel_node = reg_addr == OFS_NODE_ID;
    wire wr_set = reg_wr && sel_set;
    wire wr_clr = reg_wr && sel_clr;
    wire wr_node = reg_wr && sel_node;

    wire set_src = wr_set && reg_wdata[LC_ROLL_SRC_BIT];
    wire clr_src = wr_clr && reg_wdata[LC_ROLL_SRC_BIT];
    wire set_cnt = wr_set && reg_wdata[LC_CNT_EN_BIT];
    wire clr_cnt = wr_clr && reg_wdata[LC_CNT_EN_BIT];
    wire set_phy = wr_set && reg_wdata[LC_PHY_PKT_BIT];
    wire clr_phy = wr_clr && reg_wdata[LC_PHY_PKT_BIT];
    wire set_sid = wr_set && reg_wdata[LC_SELF_ID_BIT];
    wire clr_sid = wr_clr && reg_wdata[LC_SELF_ID_BIT];
    // a pending overlong event blocks the set; the event itself beats software
    wire set_mst = wr_set && reg_wdata[LC_MASTER_BIT] && !interrupt_event_register_overlong;
    wire clr_mst = (wr_clr && reg_wdata[LC_MASTER_BIT]) || overlong_cycle_event;

    wire next_master = overlong_cycle_event ? 1'b0
                     : sc_next(cycle_start_generator_enable, set_mst, clr_mst);

    // undescribed bits read as zero and writes to them are dropped
    wire [31:0] link_word = place(rollover_source_select, LC_ROLL_SRC_BIT)
                          | place(cycle_start_generator_enable, LC_MASTER_BIT)
                          | place(offset_count_enable, LC_CNT_EN_BIT)
                          | place(accept_phy_packets, LC_PHY_PKT_BIT)
                          | place(accept_self_identification, LC_SELF_ID_BIT);
    wire [31:0] node_word = place(node_number_valid, NI_VALID_BIT)
                          | place(node_root, NI_ROOT_BIT)
                          | place(cable_power_ok, NI_POWER_BIT)
                          | {16'h0, bus_index, physical_node_index};
    logic [7:0] pri_limit;
    logic [7:0] pri_count;
    wire [31:0] fair_word = {24'h0, pri_limit};
    wire [31:0] rd_word = sel_fair ? fair_word
                        : (sel_set || sel_clr) ? link_word
                        : sel_node ? node_word
                        : 32'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // external cycle tick: three stages, an edge counts once stages two and three agree

    logic tick_s1;
    logic tick_s2;
    logic tick_s3;
    logic tick_level;
    wire tick_agree = tick_s2 == tick_s3;
    wire ext_tick_rise = tick_agree && tick_s3 && !tick_level;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            tick_s1 <= 1'b0;
            tick_s2 <= 1'b0;
            tick_s3 <= 1'b0;
            tick_level <= 1'b0;
        end
        else
        begin
            tick_s1 <= external_cycle_tick_input;
            tick_s2 <= tick_s1;
            tick_s3 <= tick_s2;
            if (tick_agree)
            begin
                tick_level <= tick_s3;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // link control set/clear flags

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rollover_source_select <= 1'b0;
            cycle_start_generator_enable <= 1'b0;
            offset_count_enable <= 1'b0;
            accept_phy_packets <= 1'b0;
            accept_self_identification <= 1'b0;
        end
        else
        begin
            rollover_source_select <= sc_next(rollover_source_select, set_src, clr_src);
            cycle_start_generator_enable <= next_master;
            offset_count_enable <= sc_next(offset_count_enable, set_cnt, clr_cnt);
            accept_phy_packets <= sc_next(accept_phy_packets, set_phy, clr_phy);
            accept_self_identification <= sc_next(accept_self_identification, set_sid, clr_sid);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // node identity

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            node_number_valid <= 1'b0;
            node_root <= 1'b0;
            cable_power_ok <= 1'b0;
            bus_index <= BUS_INDEX_RESET;
            physical_node_index <= NODE_INDEX_RESET;
        end
        else
        begin
            // a new number in the reset cycle still marks the id valid
            if (phy_node_update)
            begin
                node_number_valid <= 1'b1;
                node_root <= phy_is_root;
                physical_node_index <= phy_node_number;
            end
            else if (phy_bus_reset)
            begin
                node_number_valid <= 1'b0;
                node_root <= 1'b0;
            end
            cable_power_ok <= phy_cable_power;
            if (wr_node)
            begin
                bus_index <= reg_wdata[NI_BUS_LSB +: BUS_W];
            end
        end
    end

    assign node_id = {bus_index, physical_node_index};

    ////////////////////////////////////////////////////////////////////////////////
    // fairness: priority requests granted up to the limit per interval

    wire [7:0] base_count = fairness_interval_start ? 8'h00 : pri_count;
    wire pri_grant = pri_arb_want && (base_count < pri_limit);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pri_limit <= PRI_REQ_LIMIT;
            pri_count <= 8'h00;
            pri_arb_req <= 1'b0;
        end
        else
        begin
            pri_count <= pri_grant ? base_count + 8'h01 : base_count;
            pri_arb_req <= pri_grant;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // cycle timer, receive gating, read port

    logic timer_roll;
    // a master ignores incoming cycle starts; a follower resynchronises on them
    wire timer_load = rx_cycle_start && !cycle_start_generator_enable;

    lcc_cycle_timer u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .count_en(offset_count_enable),
        .ext_source(rollover_source_select),
        .ext_tick(ext_tick_rise),
        .load(timer_load),
        .load_value(rx_cycle_start_data),
        .offset(cycle_tick_offset),
        .count(cycle_counter_field),
        .seconds(cycle_seconds_field),
        .rollover(timer_roll)
    );

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cycle_start_send <= 1'b0;
            queue_phy_packet <= 1'b0;
            queue_self_id_packet <= 1'b0;
            reg_rdata <= 32'h0;
            reg_rd_valid <= 1'b0;
        end
        else
        begin
            cycle_start_send <= timer_roll && cycle_start_generator_enable && node_root;
            queue_phy_packet <= rx_phy_packet && accept_phy_packets
                                && async_receive_request_run;
            queue_self_id_packet <= rx_self_id_packet && accept_self_identification;
            reg_rdata <= reg_rd ? rd_word : 32'h0;
            reg_rd_valid <= reg_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_fair_cap;
        pri_count <= pri_limit;
    endproperty
    a_fair_cap: assert property (p_fair_cap) else $error("priority count over limit");

    property p_fair_grant;
        pri_arb_want && fairness_interval_start && pri_limit != 8'h00 |=> pri_arb_req;
    endproperty
    a_fair_grant: assert property (p_fair_grant) else $error("priority request withheld");

    sequence s_set_cnt;
        wr_set && reg_wdata[LC_CNT_EN_BIT];
    endsequence
    sequence s_clr_cnt;
        wr_clr && reg_wdata[LC_CNT_EN_BIT];
    endsequence
    property p_set_then_clr;
        s_set_cnt ##1 !reg_wr ##1 s_clr_cnt |-> offset_count_enable ##1 !offset_count_enable;
    endproperty
    a_set_then_clr: assert property (p_set_then_clr) else $error("set/clear failed");

    property p_zero_write;
        wr_set && reg_wdata == 32'h0 && !overlong_cycle_event |=> $stable(link_word);
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write changed flags");

    property p_same_view;
        reg_rd && (sel_set || sel_clr) |=> reg_rd_valid && reg_rdata == $past(link_word);
    endproperty
    a_same_view: assert property (p_same_view) else $error("view read mismatch");

    property p_unmapped;
        reg_rd && !(sel_fair || sel_set || sel_clr || sel_node) |=> reg_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_overlong;
        overlong_cycle_event |=> !cycle_start_generator_enable;
    endproperty
    a_overlong: assert property (p_overlong) else $error("master kept after overlong");

    property p_refuse;
        interrupt_event_register_overlong && !cycle_start_generator_enable
        |=> !cycle_start_generator_enable;
    endproperty
    a_refuse: assert property (p_refuse) else $error("master set while pending");

    property p_master_send;
        timer_roll && cycle_start_generator_enable && node_root |=> cycle_start_send;
    endproperty
    a_master_send: assert property (p_master_send) else $error("cycle start not sent");

    property p_no_send;
        !node_root |=> !cycle_start_send;
    endproperty
    a_no_send: assert property (p_no_send) else $error("cycle start sent off root");

    property p_node_load;
        phy_node_update |=> node_number_valid && physical_node_index == $past(phy_node_number)
                            && node_root == $past(phy_is_root);
    endproperty
    a_node_load: assert property (p_node_load) else $error("node number not loaded");

    property p_bus_reset;
        phy_bus_reset && !phy_node_update |=> !node_number_valid;
    endproperty
    a_bus_reset: assert property (p_bus_reset) else $error("valid kept over bus reset");

    property p_power;
        ##1 cable_power_ok == $past(phy_cable_power);
    endproperty
    a_power: assert property (p_power) else $error("cable power flag lags");

    property p_self_id;
        rx_self_id_packet |=> queue_self_id_packet == $past(accept_self_identification);
    endproperty
    a_self_id: assert property (p_self_id) else $error("self-id gating wrong");

    property p_phy_pkt;
        rx_phy_packet && !(accept_phy_packets && async_receive_request_run)
        |=> !queue_phy_packet;
    endproperty
    a_phy_pkt: assert property (p_phy_pkt) else $error("phy packet queued");

endmodule

// ===== tb/lcc_phy_model.sv
module lcc_phy_model
    import lcc_pkg::*;
(
    input wire logic clk,
    output logic phy_bus_reset,
    output logic phy_node_update,
    output logic [NODE_W-1:0] phy_node_number,
    output logic phy_is_root,
    output logic phy_cable_power
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        phy_bus_reset = 1'b0;
        phy_node_update = 1'b0;
        phy_node_number = 6'h2a;
        phy_is_root = 1'b0;
        phy_cable_power = 1'b0;
    end

    task automatic bus_reset();
        @(negedge clk);
        phy_bus_reset = 1'b1;
        @(negedge clk);
        phy_bus_reset = 1'b0;
    endtask

    // number only qualified by the strobe; inverted afterwards so stale use shows
    task automatic self_id(input logic [NODE_W-1:0] num, input logic root);
        @(negedge clk);
        phy_node_update = 1'b1;
        phy_node_number = num;
        phy_is_root = root;
        @(negedge clk);
        phy_node_update = 1'b0;
        phy_node_number = ~num;
    endtask

    task automatic power(input logic ok);
        @(negedge clk);
        phy_cable_power = ok;
    endtask
endmodule

// ===== tb/lcc_link_core_control_regs_bench.sv
module lcc_link_core_control_regs_bench
    import lcc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed
    {
        logic [7:0] wa;
        logic [31:0] wd;
        logic [7:0] ra;
        logic [31:0] ex;
    } lcc_row_s;

    lcc_row_s rows [8] = '{
        '{8'he0, 32'hffffffff, 8'he4, 32'h00700600},
        '{8'he4, 32'h00100000, 8'he0, 32'h00600600},
        '{8'he4, 32'h00000000, 8'he0, 32'h00600600},
        '{8'he0, 32'h00000000, 8'he4, 32'h00600600},
        '{8'he4, 32'hffffffff, 8'he4, 32'h00000000},
        '{8'he8, 32'hffff5540, 8'he8, 32'h0000557f},
        '{8'hdc, 32'hffffffff, 8'hdc, 32'h00000002},
        '{8'hf0, 32'hffffffff, 8'hf0, 32'h00000000}};

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic reg_rd_valid;
    logic ext_tick = 1'b0;
    logic ovl = 1'b0;
    logic ovl_pend = 1'b0;
    logic rx_cs = 1'b0;
    logic [31:0] rx_cs_data = 32'h0;
    logic rx_phy = 1'b0;
    logic rx_sid = 1'b0;
    logic ar_run = 1'b0;
    logic want = 1'b0;
    logic fair_start = 1'b0;
    logic bus_rst, node_upd, is_root, cab_pwr;
    logic [NODE_W-1:0] node_num;
    logic pri_req, cs_send, q_phy, q_sid, src, master, cnt_en, acc_phy, acc_sid;
    logic valid, root, pwr_ok;
    logic [BUS_W-1:0] bus;
    logic [NODE_W-1:0] node;
    logic [15:0] nid;
    logic [OFS_W-1:0] ofs;
    logic [CNT_W-1:0] cnt;
    logic [SEC_W-1:0] sec;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    int n_req = 0;
    int n_cs = 0;

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    lcc_phy_model phy (.clk(clk), .phy_bus_reset(bus_rst), .phy_node_update(node_upd),
        .phy_node_number(node_num), .phy_is_root(is_root), .phy_cable_power(cab_pwr));

    lcc_link_core_control_regs #(.PRI_REQ_LIMIT(8'h02)) dut (.clk(clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .external_cycle_tick_input(ext_tick), .overlong_cycle_event(ovl),
        .interrupt_event_register_overlong(ovl_pend), .phy_bus_reset(bus_rst),
        .phy_node_update(node_upd), .phy_node_number(node_num), .phy_is_root(is_root),
        .phy_cable_power(cab_pwr), .rx_cycle_start(rx_cs), .rx_cycle_start_data(rx_cs_data),
        .rx_phy_packet(rx_phy), .rx_self_id_packet(rx_sid), .async_receive_request_run(ar_run),
        .pri_arb_want(want), .fairness_interval_start(fair_start), .pri_arb_req(pri_req),
        .cycle_start_send(cs_send), .queue_phy_packet(q_phy), .queue_self_id_packet(q_sid),
        .rollover_source_select(src), .cycle_start_generator_enable(master),
        .offset_count_enable(cnt_en), .accept_phy_packets(acc_phy),
        .accept_self_identification(acc_sid), .node_number_valid(valid), .node_root(root),
        .cable_power_ok(pwr_ok), .bus_index(bus), .physical_node_index(node), .node_id(nid),
        .cycle_tick_offset(ofs), .cycle_counter_field(cnt), .cycle_seconds_field(sec));

    always @(posedge clk)
    begin
        cyc++;
        n_req += (pri_req === 1'b1);
        n_cs += (cs_send === 1'b1);
        if (cyc == 20000)
        begin
            n_fail++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", name, e, g);
            n_fail++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        chk("rd_valid", 32'h1, {31'h0, reg_rd_valid});
        d = reg_rdata;
    endtask

    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    task automatic finish_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] v;
        int n;
        int k;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        rd(8'he8, v);
        chk("node_identity", 32'h0000ffff, v);
        rd(8'he0, v);
        chk("link_control", 32'h0, v);
        rd(8'hdc, v);
        chk("fairness", 32'h2, v);
        done("reset");
        foreach (rows[i])
        begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra, v);
            chk("register", rows[i].ex, v);
        end
        done("table");
        wr(8'he0, 32'h00200000);
        ovl = 1'b1;
        ovl_pend = 1'b1;
        @(negedge clk);
        ovl = 1'b0;
        chk("master_cleared", 32'h0, {31'h0, master});
        wr(8'he0, 32'h00200000);
        chk("master_refused", 32'h0, {31'h0, master});
        ovl_pend = 1'b0;
        wr(8'he0, 32'h00200000);
        chk("master_set", 32'h1, {31'h0, master});
        v = {sec, cnt, ofs};
        rx_cs_data = 32'haaaa5555;
        rx_cs = 1'b1;
        @(negedge clk);
        rx_cs = 1'b0;
        chk("master_ignores_start", v, {sec, cnt, ofs});
        wr(8'he4, 32'h00200000);
        wr(8'he0, 32'h00100000);
        chk("count_enable_set", 32'h1, {31'h0, cnt_en});
        wr(8'he4, 32'h00100000);
        chk("count_enable_clear", 32'h0, {31'h0, cnt_en});
        done("overlong");
        phy.power(1'b1);
        phy.self_id(6'h05, 1'b1);
        chk("node_flags", 32'h7, {29'h0, valid, root, pwr_ok});
        chk("node_id", {16'h0, 10'h155, 6'h05}, {16'h0, nid});
        chk("node_fields", {16'h0, 10'h155, 6'h05}, {16'h0, bus, node});
        phy.bus_reset();
        phy.power(1'b0);
        @(negedge clk);
        chk("after_bus_reset", 32'h0, {29'h0, valid, root, pwr_ok});
        phy.self_id(6'h05, 1'b1);
        done("phy");
        n = n_req;
        fair_start = 1'b1;
        want = 1'b1;
        @(negedge clk);
        fair_start = 1'b0;
        repeat (3) @(negedge clk);
        want = 1'b0;
        repeat (2) @(negedge clk);
        chk("priority_requests", 32'h2, n_req - n);
        done("fairness");
        for (int i = 0; i < 4; i++)
        begin
            wr(8'he4, 32'h00000600);
            if (i[0])
                wr(8'he0, 32'h00000600);
            ar_run = i[1];
            @(negedge clk);
            rx_phy = 1'b1;
            rx_sid = 1'b1;
            @(negedge clk);
            rx_phy = 1'b0;
            rx_sid = 1'b0;
            chk("queue", {30'h0, i[0] & i[1], i[0]}, {30'h0, q_phy, q_sid});
            chk("accept_pins", {30'h0, i[0], i[0]}, {30'h0, acc_phy, acc_sid});
        end
        done("receive");
        wr(8'he4, 32'h00700600);
        @(negedge clk);
        rx_cs = 1'b1;
        rx_cs_data = {7'h7f, 13'd7999, 12'd3060};
        @(negedge clk);
        rx_cs = 1'b0;
        chk("timer_load", {7'h7f, 13'd7999, 12'd3060}, {sec, cnt, ofs});
        n = n_cs;
        wr(8'he0, 32'h00300000);
        // twelve offset ticks of about 8.14 clocks each before the wrap
        for (k = 0; k < 300 && n_cs == n; k++)
            @(negedge clk);
        chk("cycle_start", 32'h1, n_cs - n);
        chk("roll_time", 32'h1, {31'h0, k >= 85 && k <= 115});
        chk("wrap", 32'h0, {12'h0, sec, cnt});
        wr(8'he4, 32'h00300000);
        v = {20'h0, ofs};
        repeat (40) @(negedge clk);
        chk("offset_hold", v, {20'h0, ofs});
        wr(8'he0, 32'h00400000);
        chk("source_pin", 32'h1, {31'h0, src});
        v = {19'h0, cnt} + 32'h1;
        ext_tick = 1'b1;
        repeat (8) @(negedge clk);
        ext_tick = 1'b0;
        chk("ext_roll", v, {19'h0, cnt});
        chk("ext_offset", 32'h1, {31'h0, ofs < 12'h010});
        done("timer");
        finish_test();
    end
endmodule
